/* rtl/dpp_pkg.sv */
/*
  Package of the data pointer and power control register bank.
  Assumes the core addresses this bank with 8-bit register addresses.
*/
`default_nettype none
package dpp_pkg;
  localparam logic [7:0] ADDR_PRIMARY_LOW = 8'h82;
  localparam logic [7:0] ADDR_PRIMARY_HIGH = 8'h83;
  localparam logic [7:0] ADDR_SECOND_LOW = 8'h84;
  localparam logic [7:0] ADDR_SECOND_HIGH = 8'h85;
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_POINTER_SELECT = 8'h92;
  localparam logic [2:0] BIT_ADDRESSABLE_LOW = 3'h0;
  localparam int PTR_WIDTH = 16;
  localparam int BYTE_WIDTH = 8;
  localparam int NUM_POINTERS = 2;
  localparam int SEL_BIT = 0;
  localparam int PC_BAUD_DOUBLE = 7;
  localparam int PC_USER_FLAG_THREE = 6;
  localparam int PC_USER_FLAG_TWO = 5;
  localparam int PC_PROG_WRITE = 4;
  localparam int PC_USER_FLAG_ONE = 3;
  localparam int PC_USER_FLAG_ZERO = 2;
  localparam logic [7:0] PC_WRITABLE_MASK = 8'hFC;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic RESET_SEL = 1'b0;
endpackage
`default_nettype wire

/* rtl/dpp_ptr_if.sv */
/*
  Carrier between the register bank and one pointer register pair.
  Assumes a single clock shared by both ends.
*/
`timescale 1ns/100ps
`default_nettype none
interface dpp_ptr_if;
  logic low_wr;
  logic high_wr;
  logic [7:0] byte_data;
  logic word_wr;
  logic [15:0] word_data;
  logic [15:0] value;
  modport bank (output low_wr, high_wr, byte_data, word_wr, word_data,
    input value);
  modport ptr (input low_wr, high_wr, byte_data, word_wr, word_data,
    output value);
endinterface
`default_nettype wire

/* rtl/dpp_ptr_reg.sv */
/*
  One 16-bit pointer held as two byte registers.
  Assumes the bank never asks for a word and a byte write of the same
  pointer at once; if it does, the word write wins.
*/
`timescale 1ns/100ps
`default_nettype none
module dpp_ptr_reg
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Bank side
  dpp_ptr_if.ptr bus
);

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } dpp_ptr_state_t;

  dpp_ptr_state_t state;
  dpp_ptr_state_t next_state;

  always_comb
  begin
    next_state = state;
    if (bus.low_wr)
    begin
      next_state.low = bus.byte_data; // R5
    end
    if (bus.high_wr)
    begin
      next_state.high = bus.byte_data; // R5
    end
    if (bus.word_wr)
    begin
      next_state = bus.word_data; // R5
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state <= dpp_pkg::RESET_WORD; // R11
    end
    else
    begin
      state <= next_state;
    end
  end

  assign bus.value = state;

endmodule // dpp_ptr_reg
`default_nettype wire

/* rtl/dpp_sfr_bank.sv */
/*
  Dual data pointer, pointer select and power control register bank.
  Assumes the core drives a synchronous register bus on mclk_in: byte
  reads and writes by address, bit writes by bit address, and 16-bit
  writes of the selected pointer.
*/
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// R1: Two 16-bit pointers exist and a select register picks the active one.
// R2: Select bit 0 picks primary (0) or second (1); bits 7 to 1 are unused.
// R3: The selected pointer gives the indirect address for moves and jumps.
// R4: The second pointer has its low byte at 0x84 and high byte at 0x85.
// R5: Pointers are read and written as words or as independent bytes.
// R6: Power control bit 7 drives the serial port 0 baud doubler.
// R7: Power control bit 4 enables program memory write mode.
// R8: Power control bits 6, 5, 3 and 2 are plain flag storage.
// R9: Power control bits 1 and 0 are written zero and always read zero.
// R10: Only addresses ending in 000 take bit access; others take bytes.
// R11: Select register and all pointer bytes reset to zero.
// R12: Software avoids unmapped addresses; they read zero, writes ignored.
module dpp_sfr_bank
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Byte access
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  // Bit access
  input wire logic sfr_bit_wr_in,
  input wire logic [7:0] sfr_bit_addr_in,
  input wire logic sfr_bit_val_in,
  // Word access to the selected pointer
  input wire logic ptr_word_wr_in,
  input wire logic [15:0] ptr_word_in,
  // Read answer
  output logic [7:0] sfr_rdata_out,
  output logic sfr_rvalid_out,
  // Block outputs
  output logic [15:0] indirect_address_pointer_out,
  output logic baud_double_out,
  output logic prog_write_en_out
);

  typedef struct packed {
    logic [7:0] rdata;
    logic rvalid;
    logic [15:0] indirect;
    logic sel;
    logic [7:0] power_control;
  } dpp_bank_state_t;

  dpp_bank_state_t state;
  dpp_bank_state_t next_state;

  dpp_ptr_if ptr_bus [dpp_pkg::NUM_POINTERS] ();
  logic [15:0] ptr_value [dpp_pkg::NUM_POINTERS];

  ////////////////////////////////////////////////////////////////////////
  // Decoding

  function automatic logic bit_addressable(input logic [7:0] addr);
    bit_addressable = (addr[2:0] == dpp_pkg::BIT_ADDRESSABLE_LOW); // R10
  endfunction

  function automatic logic [7:0] low_addr(input int idx);
    low_addr = (idx == 0) ? dpp_pkg::ADDR_PRIMARY_LOW
      : dpp_pkg::ADDR_SECOND_LOW; // R4
  endfunction

  function automatic logic [7:0] high_addr(input int idx);
    high_addr = (idx == 0) ? dpp_pkg::ADDR_PRIMARY_HIGH
      : dpp_pkg::ADDR_SECOND_HIGH; // R4
  endfunction

  // Keeps the flag, doubler and write mode bits; bits 1 and 0 hold zero
  function automatic logic [7:0] pc_store(input logic [7:0] data);
    logic [7:0] kept;
    kept = 8'h00;
    kept[dpp_pkg::PC_BAUD_DOUBLE] = data[dpp_pkg::PC_BAUD_DOUBLE]; // R6
    kept[dpp_pkg::PC_USER_FLAG_THREE] =
      data[dpp_pkg::PC_USER_FLAG_THREE]; // R8
    kept[dpp_pkg::PC_USER_FLAG_TWO] = data[dpp_pkg::PC_USER_FLAG_TWO]; // R8
    kept[dpp_pkg::PC_PROG_WRITE] = data[dpp_pkg::PC_PROG_WRITE]; // R7
    kept[dpp_pkg::PC_USER_FLAG_ONE] = data[dpp_pkg::PC_USER_FLAG_ONE]; // R8
    kept[dpp_pkg::PC_USER_FLAG_ZERO] = data[dpp_pkg::PC_USER_FLAG_ZERO]; // R8
    pc_store = kept; // R9
  endfunction

  // Byte address and lane of a bit access; bit groups start on X000
  // bytes, and no register of this bank sits there, so bit writes miss
  logic [7:0] bit_byte_addr;
  logic [2:0] bit_lane;
  logic bit_hit_allowed;
  assign bit_byte_addr = {sfr_bit_addr_in[7:3], 3'h0};
  assign bit_lane = sfr_bit_addr_in[2:0];
  assign bit_hit_allowed = sfr_bit_wr_in && bit_addressable(bit_byte_addr);

  ////////////////////////////////////////////////////////////////////////
  // Pointer pairs

  genvar g;
  generate
    for (g = 0; g < dpp_pkg::NUM_POINTERS; g++)
    begin : g_ptr
      logic [7:0] bit_base;
      logic [7:0] bit_merged;
      logic bit_low;
      logic bit_high;
      // A bit access only reaches a byte whose address ends in 000
      assign bit_low = bit_hit_allowed && (bit_byte_addr == low_addr(g)); // R10
      assign bit_high = bit_hit_allowed && (bit_byte_addr == high_addr(g)); // R10
      assign bit_base = bit_low ? ptr_value[g][7:0] : ptr_value[g][15:8];
      always_comb
      begin
        bit_merged = bit_base;
        bit_merged[bit_lane] = sfr_bit_val_in;
      end
      assign ptr_bus[g].low_wr = (sfr_wr_in && (sfr_addr_in == low_addr(g)))
        || bit_low; // R5
      assign ptr_bus[g].high_wr = (sfr_wr_in && (sfr_addr_in == high_addr(g)))
        || bit_high; // R5
      assign ptr_bus[g].byte_data = (bit_low || bit_high) ? bit_merged
        : sfr_wdata_in;
      assign ptr_bus[g].word_wr = ptr_word_wr_in
        && (state.sel == 1'(g)); // R1
      assign ptr_bus[g].word_data = ptr_word_in;
      assign ptr_value[g] = ptr_bus[g].value;
      dpp_ptr_reg u_ptr
      (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .bus(ptr_bus[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Bank state

  logic [7:0] read_mux;
  logic [7:0] bit_pc;
  logic [7:0] bit_sel;

  always_comb
  begin
    unique case (sfr_addr_in)
      dpp_pkg::ADDR_PRIMARY_LOW: read_mux = ptr_value[0][7:0]; // R5
      dpp_pkg::ADDR_PRIMARY_HIGH: read_mux = ptr_value[0][15:8];
      dpp_pkg::ADDR_SECOND_LOW: read_mux = ptr_value[1][7:0]; // R4
      dpp_pkg::ADDR_SECOND_HIGH: read_mux = ptr_value[1][15:8]; // R4
      dpp_pkg::ADDR_POWER_CONTROL:
        read_mux = state.power_control & dpp_pkg::PC_WRITABLE_MASK; // R9
      dpp_pkg::ADDR_POINTER_SELECT: read_mux = {7'h00, state.sel}; // R2
      default: read_mux = 8'h00; // R12
    endcase
  end

  always_comb
  begin
    bit_pc = state.power_control;
    bit_pc[bit_lane] = sfr_bit_val_in;
    bit_sel = {7'h00, state.sel};
    bit_sel[bit_lane] = sfr_bit_val_in;
  end

  always_comb
  begin
    next_state = state;
    next_state.rvalid = sfr_rd_in;
    next_state.rdata = sfr_rd_in ? read_mux : 8'h00;
    if (sfr_wr_in && (sfr_addr_in == dpp_pkg::ADDR_POWER_CONTROL))
    begin
      // Flags, baud doubler and write mode stored; low two bits dropped
      next_state.power_control = pc_store(sfr_wdata_in); // R6 R7 R8 R9
    end
    else if (bit_hit_allowed
      && (bit_byte_addr == dpp_pkg::ADDR_POWER_CONTROL))
    begin
      next_state.power_control = pc_store(bit_pc); // R10
    end
    if (sfr_wr_in && (sfr_addr_in == dpp_pkg::ADDR_POINTER_SELECT))
    begin
      next_state.sel = sfr_wdata_in[dpp_pkg::SEL_BIT]; // R2
    end
    else if (bit_hit_allowed
      && (bit_byte_addr == dpp_pkg::ADDR_POINTER_SELECT))
    begin
      next_state.sel = bit_sel[dpp_pkg::SEL_BIT]; // R10
    end
    // Follows a new select in the same cycle and the pointer contents one cycle later
    next_state.indirect = next_state.sel ? ptr_value[1] : ptr_value[0]; // R3
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state.rdata <= dpp_pkg::RESET_BYTE;
      state.rvalid <= 1'b0;
      state.indirect <= dpp_pkg::RESET_WORD;
      state.sel <= dpp_pkg::RESET_SEL; // R11
      state.power_control <= dpp_pkg::RESET_BYTE;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign sfr_rdata_out = state.rdata;
  assign sfr_rvalid_out = state.rvalid;
  assign indirect_address_pointer_out = state.indirect; // R3
  assign baud_double_out = state.power_control[dpp_pkg::PC_BAUD_DOUBLE]; // R6
  assign prog_write_en_out = state.power_control[dpp_pkg::PC_PROG_WRITE]; // R7

endmodule // dpp_sfr_bank
`default_nettype wire

/* tb/dpp_core_model.sv */
/* Core side of the register bus, driven by task calls.
   Assumes the bank samples on the rising edge of mclk_in. */
`timescale 1ns/100ps
`default_nettype none
module dpp_core_model
(
  // Clock and answer
  input wire logic mclk_in,
  input wire logic [7:0] rdata_in,
  input wire logic rvalid_in,
  // Requests
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  output logic [7:0] baddr_out,
  output logic wr_out,
  output logic rd_out,
  output logic bwr_out,
  output logic bval_out,
  output logic wwr_out,
  output logic [15:0] word_out
);
  initial
  begin
    {addr_out, wdata_out, baddr_out, wr_out, rd_out} = '0;
    {bwr_out, bval_out, wwr_out, word_out} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    {addr_out, wdata_out, wr_out} <= {a, d, 1'b1};
    @(posedge mclk_in);
    {wdata_out, wr_out} <= {~d, 1'b0};
  endtask
  task automatic bw(input logic [7:0] a, input logic v);
    @(posedge mclk_in);
    {baddr_out, bval_out, bwr_out} <= {a, v, 1'b1};
    @(posedge mclk_in);
    {bval_out, bwr_out} <= {~v, 1'b0};
  endtask
  task automatic ww(input logic [15:0] w);
    @(posedge mclk_in);
    {word_out, wwr_out} <= {w, 1'b1};
    @(posedge mclk_in);
    {word_out, wwr_out} <= {~w, 1'b0};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
    @(posedge mclk_in);
    {addr_out, rd_out} <= {a, 1'b1};
    @(posedge mclk_in);
    rd_out <= 1'b0;
    {ok, d} = '0;
    repeat (3)
    begin
      @(negedge mclk_in);
      if (!ok && rvalid_in === 1'b1)
        {ok, d} = {1'b1, rdata_in};
    end
  endtask
endmodule // dpp_core_model
`default_nettype wire

/* tb/dpp_sfr_bank_sva.sv */
/* Port assertions of the register bank.
   Assumes one clock and the bind at the foot. */
`timescale 1ns/100ps
`default_nettype none
module dpp_chk
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Byte, bit and word requests
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic [7:0] sfr_bit_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic sfr_bit_wr_in,
  input wire logic sfr_bit_val_in,
  input wire logic ptr_word_wr_in,
  input wire logic [15:0] ptr_word_in,
  // Bank outputs
  input wire logic [7:0] sfr_rdata_out,
  input wire logic sfr_rvalid_out,
  input wire logic baud_double_out,
  input wire logic prog_write_en_out,
  input wire logic [15:0] indirect_address_pointer_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_pc_wr; sfr_wr_in && sfr_addr_in == 8'h87 ##1 !sfr_wr_in;
  endsequence
  sequence s_bit_q; sfr_bit_wr_in && !sfr_wr_in; endsequence
  sequence s_word; ptr_word_wr_in && !sfr_wr_in
    ##1 !sfr_wr_in && !ptr_word_wr_in; endsequence
  property p_rv; sfr_rd_in |=> sfr_rvalid_out; endproperty
  a_rv: assert property (p_rv) else $error("read answer missing");
  property p_idle; !sfr_rd_in |=> !sfr_rvalid_out && sfr_rdata_out == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("answer without read");
  property p_baud; s_pc_wr |=> baud_double_out == $past(sfr_wdata_in[7], 2);
  endproperty
  a_baud: assert property (p_baud) else $error("baud output wrong");
  property p_pmw; s_pc_wr |=> prog_write_en_out == $past(sfr_wdata_in[4], 2);
  endproperty
  a_pmw: assert property (p_pmw) else $error("write mode wrong");
  property p_pcrd; sfr_rd_in && sfr_addr_in == 8'h87
    |=> sfr_rdata_out[1:0] == 2'b00; endproperty
  a_pcrd: assert property (p_pcrd) else $error("low bits not zero");
  property p_selrd; sfr_rd_in && sfr_addr_in == 8'h92
    |=> sfr_rdata_out[7:1] == 7'h00; endproperty
  a_selrd: assert property (p_selrd) else $error("select high bits");
  property p_unmap; sfr_rd_in && sfr_addr_in == 8'h81
    |=> sfr_rvalid_out && sfr_rdata_out == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped not zero");
  property p_word; s_word
    |=> indirect_address_pointer_out == $past(ptr_word_in, 2); endproperty
  a_word: assert property (p_word) else $error("word write lost");
  property p_bit; s_bit_q |=> $stable(baud_double_out)
    && $stable(prog_write_en_out); endproperty
  a_bit: assert property (p_bit) else $error("bit write landed");
endmodule // dpp_chk
bind dpp_sfr_bank dpp_chk dpp_chk_i (.mclk_in, .sys_rst_in, .sfr_addr_in,
  .sfr_wdata_in, .sfr_bit_addr_in, .sfr_wr_in, .sfr_rd_in, .sfr_bit_wr_in,
  .sfr_bit_val_in, .ptr_word_wr_in, .ptr_word_in, .sfr_rdata_out,
  .sfr_rvalid_out, .baud_double_out, .prog_write_en_out,
  .indirect_address_pointer_out);
`default_nettype wire

/* tb/dpp_sfr_bank_tb_top.sv */
/* Self-checking bench of the register bank.
   Assumes the core model drives every bank request. */
`timescale 1ns/100ps
`default_nettype none
module dpp_sfr_bank_tb_top;
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] addr, wdata, baddr, rdata;
  logic wr, rd, bwr, bval, wwr, rvalid, baud, pmw;
  logic [15:0] word, iap;
  int n_fail = 0;
  int n_compared = 0;
  logic [7:0] ta [7] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h87, 8'h92, 8'h81};
  logic [7:0] td [7] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'hFC, 8'hFF, 8'hAA};
  logic [7:0] te [7] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'hFC, 8'h01, 8'h00};
  initial
  begin
    forever #20 mclk_in = ~mclk_in;
  end
  dpp_sfr_bank dpp_sfr_bank_i (.mclk_in, .sys_rst_in, .sfr_addr_in(addr),
    .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_wdata_in(wdata),
    .sfr_bit_wr_in(bwr), .sfr_bit_addr_in(baddr), .sfr_bit_val_in(bval),
    .ptr_word_wr_in(wwr), .ptr_word_in(word), .sfr_rdata_out(rdata),
    .sfr_rvalid_out(rvalid), .indirect_address_pointer_out(iap),
    .baud_double_out(baud), .prog_write_en_out(pmw));
  dpp_core_model dpp_core_model_i (.mclk_in, .rdata_in(rdata),
    .rvalid_in(rvalid), .addr_out(addr), .wdata_out(wdata),
    .baddr_out(baddr), .wr_out(wr), .rd_out(rd), .bwr_out(bwr),
    .bval_out(bval), .wwr_out(wwr), .word_out(word));
  task automatic close_out;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, s);
    n_compared++;
    if (s !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    bit ok;
    dpp_core_model_i.rd(a, d, ok);
    if (!ok)
    begin
      n_fail++;
      $display("MISMATCH rvalid expected 1 seen 0");
      close_out();
    end
    else
      chk("rdata", {8'h00, e}, {8'h00, d});
  endtask
  initial
  begin
    repeat (12) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    foreach (ta[i]) rchk(ta[i], 8'h00);
    foreach (ta[i]) dpp_core_model_i.wr(ta[i], td[i]);
    foreach (ta[i]) rchk(ta[i], te[i]);
    chk("outs", 16'h0003, {14'h0000, baud, pmw});
    chk("iap", 16'h7856, iap);
    dpp_core_model_i.wr(8'h87, 8'h6C);
    dpp_core_model_i.bw(8'h87, 1'b1);
    rchk(8'h87, 8'h6C);
    chk("outs", 16'h0000, {14'h0000, baud, pmw});
    dpp_core_model_i.ww(16'hBEEF);
    rchk(8'h84, 8'hEF);
    rchk(8'h85, 8'hBE);
    rchk(8'h83, 8'h34);
    chk("iap", 16'hBEEF, iap);
    dpp_core_model_i.wr(8'h92, 8'h00);
    repeat (2) @(negedge mclk_in);
    chk("iap", 16'h3412, iap);
    dpp_core_model_i.ww(16'hCAFE);
    rchk(8'h82, 8'hFE);
    rchk(8'h83, 8'hCA);
    rchk(8'h84, 8'hEF);
    chk("iap", 16'hCAFE, iap);
    @(posedge mclk_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    foreach (ta[i]) rchk(ta[i], 8'h00);
    chk("iap", 16'h0000, iap);
    close_out();
  end
endmodule // dpp_sfr_bank_tb_top
`default_nettype wire
